// ===== bscp_pkg.sv
// Shared constants and types for the bridge status and control pin block
package bscp_pkg;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL     = 4'h0;
	localparam logic [3:0] OFS_STATUS   = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
	localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

	// Control register fields
	localparam int CTRL_SPEED_IND = 0;
	localparam int CTRL_PRES_POL  = 1;
	localparam int CTRL_DRV_RST   = 2;
	localparam int CTRL_W         = 3;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Status register fields
	localparam int ST_EJECT   = 0;
	localparam int ST_HOSTIRQ = 1;
	localparam int ST_PRESENT = 2;
	localparam int ST_RUN     = 3;
	localparam int ST_SUSPEND = 4;
	localparam int ST_FS      = 5;
	localparam int ST_W       = 6;

	// Interrupt status and mask fields
	localparam int EV_EJECT   = 0;
	localparam int EV_HOSTIRQ = 1;
	localparam int EV_PRESENT = 2;
	localparam int EV_ENABLE  = 3;
	localparam int EV_SUSPEND = 4;
	localparam int EV_W       = 5;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	// Raw board and core levels, sampled together
	typedef struct packed {
		logic eject_n;
		logic host_irq;
		logic presence;
		logic enable;
		logic suspended;
		logic full_speed;
	} pin_levels_t;

	localparam int PIN_W = 6;
	localparam logic [5:0] PIN_RESET = 6'h20;

endpackage : bscp_pkg

// ===== level_sync.sv
// Multi-stage level synchroniser with clock enable
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
	parameter int         WIDTH  = 1,
	parameter int         STAGES = 2,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst,
	input  wire logic             ce,
	// Levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage [STAGES];

	// First stage feeds only the next stage
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage[i] <= INIT;
			end
		end else if (ce) begin
			stage[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign q = stage[STAGES-1];
endmodule : level_sync
`default_nettype wire

// ===== bridge_status_control_pins.sv
// Control and status pin logic with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module bridge_status_control_pins
	import bscp_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        chip_reset_n,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq,
	// Board request and status inputs
	input  wire logic        eject_wake_req_n,
	input  wire logic        host_event_irq,
	input  wire logic        drive_present_detect,
	input  wire logic        storage_if_enable,
	// USB core state
	input  wire logic        usb_suspended,
	input  wire logic        usb_full_speed,
	// Levels to the bridge core
	output logic             eject_request,
	output logic             host_irq_request,
	output logic             drive_present,
	output logic             storage_if_run,
	// Pins
	output logic             speed_indicator_pin_o,
	output logic             speed_indicator_pin_oe,
	output logic             suspend_indicator_o,
	output logic             suspend_indicator_oe,
	output logic             drive_reset_n
);
	logic                 arst;
	pin_levels_t          raw;
	pin_levels_t          syn;
	pin_levels_t          prev;
	logic [CTRL_W-1:0]    ctrl;
	logic [EV_W-1:0]      irq_stat;
	logic [EV_W-1:0]      irq_mask;
	logic [EV_W-1:0]      events;
	logic [31:0]          next_readdata;
	logic                 wr_go;
	logic                 present_now;

	// Either reset source loads every register's reset value without a clock
	assign arst = rst | ~chip_reset_n;

	assign raw = '{eject_n:    eject_wake_req_n,
	               host_irq:   host_event_irq,
	               presence:   drive_present_detect,
	               enable:     storage_if_enable,
	               suspended:  usb_suspended,
	               full_speed: usb_full_speed};

	level_sync #(
		.WIDTH  (PIN_W),
		.STAGES (SYNC_STAGES),
		.INIT   (PIN_RESET)
	) u_sync (
		.clk  (clk),
		.arst (arst),
		.ce   (ce),
		.d    (raw),
		.q    (syn)
	);

	assign present_now = (syn.presence == ctrl[CTRL_PRES_POL]);

	// Request levels to the core
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			eject_request    <= 1'b0;
			host_irq_request <= 1'b0;
			drive_present    <= 1'b0;
		end else if (ce) begin
			eject_request    <= ~syn.eject_n;
			host_irq_request <= syn.host_irq;
			drive_present    <= present_now;
		end
	end

	// Storage interface run: low floats pins and halts the engine
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			storage_if_run <= 1'b0;
		end else if (ce) begin
			storage_if_run <= syn.enable;
		end
	end

	// Speed pin is only driven when software asks for it
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			speed_indicator_pin_o  <= 1'b0;
			speed_indicator_pin_oe <= 1'b0;
		end else if (ce) begin
			speed_indicator_pin_o  <= syn.full_speed;
			speed_indicator_pin_oe <= ctrl[CTRL_SPEED_IND];
		end
	end

	// Suspend indicator: pull low when active, release when suspended
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			suspend_indicator_o  <= 1'b0;
			suspend_indicator_oe <= 1'b0;
		end else if (ce) begin
			suspend_indicator_o  <= 1'b0;
			suspend_indicator_oe <= ~syn.suspended;
		end
	end

	// Drive held in reset during chip reset and on software request
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			drive_reset_n <= 1'b0;
		end else if (ce) begin
			drive_reset_n <= ~ctrl[CTRL_DRV_RST];
		end
	end

	// Previous synchronised levels for change detection
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			prev <= PIN_RESET;
		end else if (ce) begin
			prev <= syn;
		end
	end

	always_comb begin
		events              = '0;
		events[EV_EJECT]    = prev.eject_n & ~syn.eject_n;
		events[EV_HOSTIRQ]  = ~prev.host_irq & syn.host_irq;
		events[EV_PRESENT]  = prev.presence ^ syn.presence;
		events[EV_ENABLE]   = prev.enable ^ syn.enable;
		events[EV_SUSPEND]  = prev.suspended ^ syn.suspended;
	end

	// Avalon slave: one wait cycle, then a one-cycle answer
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	assign wr_go = ce && avs_write && !avs_waitrequest && avs_byteenable[0];

	always_comb begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			OFS_CTRL:     next_readdata[CTRL_W-1:0] = ctrl;
			OFS_STATUS:   next_readdata[ST_W-1:0]   = {syn.full_speed, syn.suspended,
				storage_if_run, drive_present, host_irq_request, eject_request};
			OFS_IRQ_STAT: next_readdata[EV_W-1:0]   = irq_stat;
			OFS_IRQ_MASK: next_readdata[EV_W-1:0]   = irq_mask;
			default:      next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data loaded as waitrequest drops, held otherwise
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (ce && avs_read && avs_waitrequest) begin
			avs_readdata <= next_readdata;
		end
	end

	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			ctrl     <= CTRL_RESET;
			irq_mask <= IRQ_MASK_RESET;
		end else if (wr_go) begin
			if (avs_address == OFS_CTRL) begin
				ctrl <= avs_writedata[CTRL_W-1:0];
			end
			if (avs_address == OFS_IRQ_MASK) begin
				irq_mask <= avs_writedata[EV_W-1:0];
			end
		end
	end

	// Write-one-to-clear; a new event wins over its clear
	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			irq_stat <= '0;
		end else if (ce) begin
			if (wr_go && avs_address == OFS_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~avs_writedata[EV_W-1:0]) | events;
			end else begin
				irq_stat <= irq_stat | events;
			end
		end
	end

	always_ff @(posedge clk or posedge arst) begin
		if (arst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	property p_run;
		@(posedge clk) disable iff (arst)
		ce |=> (storage_if_run == $past(syn.enable));
	endproperty
	a_run: assert property (p_run) else $error("run does not follow enable");

	property p_speed;
		@(posedge clk) disable iff (arst)
		(ce && ctrl[CTRL_SPEED_IND]) |=>
			speed_indicator_pin_oe && (speed_indicator_pin_o == $past(syn.full_speed));
	endproperty
	a_speed: assert property (p_speed) else $error("speed pin wrong");

	property p_suspend;
		@(posedge clk) disable iff (arst)
		(ce && !syn.suspended) |=> (suspend_indicator_oe && !suspend_indicator_o);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend pin not low");

	property p_chip_reset;
		@(posedge clk)
		!chip_reset_n |-> (!drive_reset_n && avs_waitrequest && !irq);
	endproperty
	a_chip_reset: assert property (p_chip_reset) else $error("chip reset ignored");

	property p_drive_reset;
		@(posedge clk) disable iff (arst)
		(ce && ctrl[CTRL_DRV_RST]) |=> !drive_reset_n;
	endproperty
	a_drive_reset: assert property (p_drive_reset) else $error("drive not reset");

	property p_eject;
		@(posedge clk) disable iff (arst)
		(ce && !syn.eject_n) |=> eject_request;
	endproperty
	a_eject: assert property (p_eject) else $error("eject request lost");

	property p_host_irq;
		@(posedge clk) disable iff (arst)
		(ce && syn.host_irq) |=> host_irq_request;
	endproperty
	a_host_irq: assert property (p_host_irq) else $error("host irq lost");

	property p_present;
		@(posedge clk) disable iff (arst)
		ce |=> (drive_present == ($past(syn.presence) == $past(ctrl[CTRL_PRES_POL])));
	endproperty
	a_present: assert property (p_present) else $error("presence polarity wrong");

	property p_sync_delay;
		@(posedge clk) disable iff (arst)
		(ce && !eject_wake_req_n) ##1 (ce && !eject_wake_req_n) ##1 ce |=> eject_request;
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync path too long");

	property p_sync_min;
		@(posedge clk) disable iff (arst)
		(ce && $rose(host_event_irq) && !host_irq_request) |=> !host_irq_request;
	endproperty
	a_sync_min: assert property (p_sync_min) else $error("input bypasses sync");

	property p_event_sticky;
		@(posedge clk) disable iff (arst)
		(ce && events[EV_EJECT]) |=> irq_stat[EV_EJECT];
	endproperty
	a_event_sticky: assert property (p_event_sticky) else $error("event lost on clear");

	property p_speed_off;
		@(posedge clk) disable iff (arst)
		(ce && !ctrl[CTRL_SPEED_IND]) |=> !speed_indicator_pin_oe;
	endproperty
	a_speed_off: assert property (p_speed_off) else $error("speed pin driven while off");

	property p_suspend_float;
		@(posedge clk) disable iff (arst)
		(ce && syn.suspended) |=> !suspend_indicator_oe;
	endproperty
	a_suspend_float: assert property (p_suspend_float) else $error("suspend pin driven while suspended");

	property p_drive_release;
		@(posedge clk) disable iff (arst)
		(ce && !ctrl[CTRL_DRV_RST]) |=> drive_reset_n;
	endproperty
	a_drive_release: assert property (p_drive_release) else $error("drive held in reset");

	property p_eject_idle;
		@(posedge clk) disable iff (arst)
		(ce && syn.eject_n) |=> !eject_request;
	endproperty
	a_eject_idle: assert property (p_eject_idle) else $error("eject request without input");

	property p_host_irq_idle;
		@(posedge clk) disable iff (arst)
		(ce && !syn.host_irq) |=> !host_irq_request;
	endproperty
	a_host_irq_idle: assert property (p_host_irq_idle) else $error("host irq without input");

	property p_ack_answer;
		@(posedge clk) disable iff (arst)
		(ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("bus request not answered");

	property p_ack_one;
		@(posedge clk) disable iff (arst)
		(ce && !avs_waitrequest) |=> avs_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");

	property p_irq_level;
		@(posedge clk) disable iff (arst)
		ce |=> (irq == $past(|(irq_stat & irq_mask)));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq does not follow masked status");

	// Low enable must hold every output where it was
	property p_ce_freeze;
		@(posedge clk) disable iff (arst)
		!ce |=> ($stable(storage_if_run) && $stable(eject_request) && $stable(drive_reset_n) && $stable(irq));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while enable low");

	property p_w1c;
		@(posedge clk) disable iff (arst)
		(wr_go && avs_address == OFS_IRQ_STAT && avs_writedata[EV_EJECT] && !events[EV_EJECT])
			|=> !irq_stat[EV_EJECT];
	endproperty
	a_w1c: assert property (p_w1c) else $error("status bit not cleared");

endmodule : bridge_status_control_pins
`default_nettype wire

// ===== board_model.sv
// Board-side model driving the bridge's request and status inputs
`timescale 1ns/10ps
`default_nettype none
module board_model
	import bscp_pkg::*;
(
	// Commanded levels
	input  wire pin_levels_t want,
	// Board pins
	output logic             eject_wake_req_n,
	output logic             host_event_irq,
	output logic             drive_present_detect,
	output logic             storage_if_enable,
	output logic             usb_suspended,
	output logic             usb_full_speed
);
	assign eject_wake_req_n     = want.eject_n;
	assign host_event_irq       = want.host_irq;
	// Never left floating
	assign drive_present_detect = want.presence;
	assign storage_if_enable    = want.enable;
	assign usb_suspended        = want.suspended;
	assign usb_full_speed       = want.full_speed;
endmodule : board_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the bridge status and control pin block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import bscp_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        chip_reset_n = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, irq, ej, hi, pd, en, su, fs;
	logic        eject_request, host_irq_request, drive_present, storage_if_run;
	logic        spd_o, spd_oe, sus_o, sus_oe, drive_reset_n;
	pin_levels_t want = 6'h20;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;
	integer      seed = 32'hd6afe243;
	logic [31:0] q, r;
	logic [5:0]  st, old;
	logic [2:0]  ctrl;

	always #25 clk = ~clk;

	bridge_status_control_pins bridge_status_control_pins_inst (.clk(clk), .rst(rst), .ce(ce),
		.chip_reset_n(chip_reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .eject_wake_req_n(ej), .host_event_irq(hi),
		.drive_present_detect(pd), .storage_if_enable(en), .usb_suspended(su), .usb_full_speed(fs),
		.eject_request(eject_request), .host_irq_request(host_irq_request), .drive_present(drive_present),
		.storage_if_run(storage_if_run), .speed_indicator_pin_o(spd_o), .speed_indicator_pin_oe(spd_oe),
		.suspend_indicator_o(sus_o), .suspend_indicator_oe(sus_oe), .drive_reset_n(drive_reset_n));

	board_model board_model_inst (.want(want), .eject_wake_req_n(ej), .host_event_irq(hi),
		.drive_present_detect(pd), .storage_if_enable(en), .usb_suspended(su), .usb_full_speed(fs));

	function automatic logic [5:0] exp_st(input pin_levels_t p, input logic pol);
		return {p.full_speed, p.suspended, p.enable, p.presence ~^ pol, p.host_irq, ~p.eject_n};
	endfunction : exp_st

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		avs_address    <= a;
		avs_write      <= wr;
		avs_read       <= ~wr;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// One idle edge keeps back-to-back calls from driving a strobe twice at once
		@(posedge clk);
	endtask : bus

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, OFS_CTRL, 32'h0, 4'hF, q);
		chk("ctrl_reset", {29'h0, CTRL_RESET}, q);
		bus(1'b0, OFS_IRQ_MASK, 32'h0, 4'hF, q);
		chk("mask_reset", {27'h0, IRQ_MASK_RESET}, q);
		bus(1'b0, 4'h2, 32'h0, 4'hF, q);
		chk("unmapped", 32'h0, q);
		bus(1'b1, OFS_CTRL, 32'h7, 4'h0, q);
		bus(1'b0, OFS_CTRL, 32'h0, 4'hF, q);
		chk("lane_off", 32'h0, q);
		$display("test registers done");
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			ctrl = r[2:0];
			bus(1'b1, OFS_CTRL, {29'h0, ctrl}, 4'hF, q);
			repeat (5) @(posedge clk);
			old = exp_st(want, ctrl[1]);
			want <= r[8:3];
			repeat (2) @(posedge clk);
			chk("sync_lag", old[3:0], {storage_if_run, drive_present, host_irq_request, eject_request});
			repeat (3) @(posedge clk);
			st = exp_st(want, ctrl[1]);
			chk("levels", st[3:0], {storage_if_run, drive_present, host_irq_request, eject_request});
			chk("speed", {ctrl[0], want.full_speed}, {spd_oe, spd_o});
			chk("suspend", {~want.suspended, 1'b0}, {sus_oe, sus_o});
			chk("drive_reset", {31'h0, ~ctrl[2]}, {31'h0, drive_reset_n});
			bus(1'b0, OFS_STATUS, 32'h0, 4'hF, q);
			chk("status", {26'h0, st}, q);
		end
		$display("test levels done");
		want <= 6'h24;
		repeat (6) @(posedge clk);
		bus(1'b1, OFS_IRQ_STAT, 32'h1F, 4'hF, q);
		bus(1'b1, OFS_IRQ_MASK, 32'h1 << EV_EJECT, 4'hF, q);
		repeat (3) @(posedge clk);
		chk("irq_idle", 32'h0, irq);
		want <= 6'h04;
		repeat (6) @(posedge clk);
		chk("irq_eject", 32'h1, irq);
		bus(1'b0, OFS_IRQ_STAT, 32'h0, 4'hF, q);
		chk("stat_eject", 32'h1, q);
		bus(1'b1, OFS_IRQ_STAT, 32'h1, 4'hF, q);
		repeat (2) @(posedge clk);
		chk("irq_clear", 32'h0, irq);
		want <= 6'h14;
		repeat (6) @(posedge clk);
		chk("irq_masked", 32'h0, irq);
		bus(1'b0, OFS_IRQ_STAT, 32'h0, 4'hF, q);
		chk("stat_host", 32'h2, q);
		$display("test interrupt done");
		ce <= 1'b0;
		old = {2'b00, storage_if_run, drive_present, host_irq_request, eject_request};
		want <= 6'h2B;
		repeat (6) @(posedge clk);
		chk("ce_frozen", old[3:0], {storage_if_run, drive_present, host_irq_request, eject_request});
		ce <= 1'b1;
		repeat (4) @(posedge clk);
		st = exp_st(want, ctrl[1]);
		chk("ce_resume", st[3:0], {storage_if_run, drive_present, host_irq_request, eject_request});
		$display("test clock enable done");
		bus(1'b1, OFS_CTRL, 32'h1, 4'hF, q);
		repeat (5) @(posedge clk);
		chip_reset_n <= 1'b0;
		// Checked between edges to prove no clock is needed
		#1;
		chk("async_reset", 32'h1, {spd_oe, storage_if_run, drive_reset_n, avs_waitrequest});
		@(posedge clk);
		chip_reset_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, OFS_CTRL, 32'h0, 4'hF, q);
		chk("ctrl_after_reset", 32'h0, q);
		$display("test chip reset done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
